// ### core/two_wire_defines.svh
// Register indices, field positions, status codes and timing counts of the two-wire master sequencer.
// Notes on behaviour
// RULE_01 - Software requests START with flag, start and enable written one, stop zero.
// RULE_02 - After a start request, wait until the bus is free before driving START.
// RULE_03 - A finished START sets the suspend flag and reports status 0x08.
// RULE_04 - A finished repeated START reports 0x10 and the master keeps the bus.
// RULE_05 - The address direction bit selects master transmit or master receive mode.
// RULE_06 - In 0x10 a read address packet is sent and receive mode is entered.
// RULE_07 - Transmit mode reports 0x18, 0x20, 0x28 and 0x30 for address and data outcomes.
// RULE_08 - In 0x18 to 0x30, clearing the flag plainly sends the loaded byte, samples ACK.
// RULE_09 - Clearing the flag with start only generates a repeated START.
// RULE_10 - Clearing the flag with stop only generates STOP, then hardware clears stop.
// RULE_11 - Clearing with start and stop gives STOP, then START, and clears stop.
// RULE_12 - Arbitration loss reports 0x38; resuming without start releases the bus.
// RULE_13 - In 0x38, resuming with start waits for a free bus and sends START.
// RULE_14 - A read address packet ends with 0x38, 0x40 or 0x48 and the flag set.
// RULE_15 - In receive mode the received byte sits in the data register when flagged.
// RULE_16 - Software returns NACK after the last wanted byte, then STOP or repeated START.
// RULE_17 - The transfer pauses while the flag is set; writing one clears it.
// RULE_18 - Software loads address plus direction into the data register before resuming.
// RULE_19 - Software keeps the enable bit one and the reserved bit zero.
// RULE_20 - Status codes read with the prescaler bits at zero.
// RULE_21 - A data write while the flag is low is dropped and sets write collision.
// RULE_22 - In 0x40 and 0x50 a byte is received and ACK follows the acknowledge enable.
// RULE_23 - Codes 0x50 and 0x58 mean a byte received with ACK or NACK returned.
// RULE_24 - An interrupt request stands while the flag and interrupt enable are both one.
// RULE_25 - The status code occupies the upper five bits of the status register.
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

`define REG_CTRL_IDX 2'h0
`define REG_STATUS_IDX 2'h1
`define REG_DATA_IDX 2'h2

`define CTRL_FLAG 7
`define CTRL_ACK_EN 6
`define CTRL_START 5
`define CTRL_STOP 4
`define CTRL_WCOL 3
`define CTRL_EN 2
`define CTRL_IE 0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CODE_START 8'h08
`define CODE_RESTART 8'h10
`define CODE_AW_ACK 8'h18
`define CODE_AW_NACK 8'h20
`define CODE_TXD_ACK 8'h28
`define CODE_TXD_NACK 8'h30
`define CODE_LOST 8'h38
`define CODE_AR_ACK 8'h40
`define CODE_AR_NACK 8'h48
`define CODE_RXD_ACK 8'h50
`define CODE_RXD_NACK 8'h58
`define CODE_IDLE 8'hF8

`define CLK_PERIOD_NS 50
`define SCL_HALF_NS 200
`define SCL_HALF_CYCLES ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### core/two_wire_pkg.sv
// Types shared by the two-wire master sequencer.
package two_wire_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_WAIT_FREE,
        ST_START_A,
        ST_START_B,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_SUSPEND,
        ST_RS_A,
        ST_RS_B,
        ST_STOP_A,
        ST_STOP_B,
        ST_STOP_C
    } seq_state_t;

    typedef enum logic [1:0] {
        XF_ADDR,
        XF_TX,
        XF_RX
    } xfer_t;

    typedef struct packed {
        seq_state_t st;
        logic [7:0] cnt;
        logic [3:0] idx;
        xfer_t xf;
        logic [7:0] sh;
        logic [7:0] rx;
        logic ack_bit;
        logic rx_mode;
        logic owner;
        logic busy;
        logic scl_p;
        logic sda_p;
        logic scl_oe;
        logic sda_oe;
        logic [7:0] code;
        logic suspend_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic write_collision;
        logic interface_enable;
        logic interrupt_enable;
        logic [7:0] data_register;
        logic aw_v;
        logic [1:0] aw_idx;
        logic w_v;
        logic [7:0] w_d;
        logic w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } seq_regs_t;

endpackage : two_wire_pkg

// ### core/two_wire_sync.sv
// Two-flop synchroniser for the sampled bus lines.
`timescale 1ns/1ps
module two_wire_sync #(
    parameter int W = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_t;

    sync_t r_q;
    sync_t r_d;

    // The first stage feeds only the second; lines rest high, so reset to ones.
    always_comb begin
        r_d.meta = d;
        r_d.stable = r_q.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_q <= '1;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.stable;

endmodule : two_wire_sync

// ### core/two_wire_master_sequencer.sv
// Master sequencer of a byte-oriented two-wire bus with an AXI4-Lite register port.
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module two_wire_master_sequencer
    import two_wire_pkg::*;
#(
    parameter logic [7:0] HALF_CYCLES = 8'(`SCL_HALF_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);

    seq_regs_t q;
    seq_regs_t d;
    logic scl_s;
    logic sda_s;
    logic timer_done;
    logic cur_bit;
    logic next_bit;
    logic lost;
    logic ack_rx;
    logic [7:0] rd;

    two_wire_sync #(
        .W(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d({scl_i, sda_i}),
        .q({scl_s, sda_s})
    );

    // Level this node places on the data line in the current bit of a byte.
    function automatic logic bit_out(input xfer_t xf, input logic [3:0] idx, input logic [7:0] sh,
                                     input logic ack);
        logic b;
        b = 1'b1;
        if (xf == XF_RX) begin
            if (idx == 4'h8) begin
                b = ~ack;
            end
        end else if (idx != 4'h8) begin
            b = sh[7];
        end
        return b;
    endfunction : bit_out

    always_comb begin
        d = q;
        rd = 8'h00;
        lost = 1'b0;
        ack_rx = ~sda_s;
        timer_done = (q.cnt == HALF_CYCLES - 8'h01);
        cur_bit = bit_out(q.xf, q.idx, q.sh, q.ack_bit);
        d.cnt = q.cnt + 8'h01;

        // Bus monitor: START marks the bus busy, STOP frees it, whoever drives them.
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        if (q.scl_p && scl_s && q.sda_p && !sda_s) begin
            d.busy = 1'b1;
        end else if (q.scl_p && scl_s && !q.sda_p && sda_s) begin
            d.busy = 1'b0;
        end

        // Write channels are taken independently and joined before the register update.
        if (awvalid && !q.aw_v) begin
            d.aw_v = 1'b1;
            d.aw_idx = awaddr[3:2];
        end
        if (wvalid && !q.w_v) begin
            d.w_v = 1'b1;
            d.w_d = wdata[7:0];
            d.w_s = wstrb[0];
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_v && q.w_v && !q.bvalid) begin
            d.aw_v = 1'b0;
            d.w_v = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RESP_OKAY;
            case (q.aw_idx)
                `REG_CTRL_IDX: begin
                    if (q.w_s) begin
                        if (q.w_d[`CTRL_FLAG]) begin
                            d.suspend_flag = 1'b0; // RULE_17
                        end
                        d.ack_enable = q.w_d[`CTRL_ACK_EN];
                        d.start_request = q.w_d[`CTRL_START];
                        d.stop_request = q.w_d[`CTRL_STOP];
                        d.interface_enable = q.w_d[`CTRL_EN];
                        d.interrupt_enable = q.w_d[`CTRL_IE];
                    end
                end
                `REG_STATUS_IDX: begin
                    d.bresp = `RESP_OKAY;
                end
                `REG_DATA_IDX: begin
                    if (q.w_s) begin
                        if (q.suspend_flag) begin
                            d.data_register = q.w_d;
                            d.write_collision = 1'b0;
                        end else begin
                            d.write_collision = 1'b1; // RULE_21
                        end
                    end
                end
                default: begin
                    d.bresp = `RESP_SLVERR;
                end
            endcase
        end

        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            case (araddr[3:2])
                `REG_CTRL_IDX: begin
                    rd[`CTRL_FLAG] = q.suspend_flag;
                    rd[`CTRL_ACK_EN] = q.ack_enable;
                    rd[`CTRL_START] = q.start_request;
                    rd[`CTRL_STOP] = q.stop_request;
                    rd[`CTRL_WCOL] = q.write_collision;
                    rd[`CTRL_EN] = q.interface_enable;
                    rd[`CTRL_IE] = q.interrupt_enable;
                end
                `REG_STATUS_IDX: begin
                    rd = {q.code[7:3], 3'h0}; // RULE_20 RULE_25
                end
                `REG_DATA_IDX: begin
                    rd = q.data_register;
                end
                default: begin
                    d.rresp = `RESP_SLVERR;
                end
            endcase
            d.rdata = rd;
        end

        // Bus sequencer; it runs after the register update so that a hardware set wins.
        case (q.st)
            ST_IDLE: begin
                if (q.interface_enable && q.start_request && !q.suspend_flag) begin
                    d.st = ST_WAIT_FREE; // RULE_01
                end
            end
            ST_WAIT_FREE: begin
                // The lines must rest high for a full half period before START is driven.
                if (q.busy || !scl_s || !sda_s) begin
                    d.cnt = 8'h00; // RULE_02
                end else if (timer_done) begin
                    d.st = ST_START_A; // RULE_02
                end
            end
            ST_START_A: begin
                if (timer_done) begin
                    d.st = ST_START_B;
                end
            end
            ST_START_B: begin
                if (timer_done) begin
                    d.code = q.owner ? `CODE_RESTART : `CODE_START; // RULE_03 RULE_04
                    d.owner = 1'b1; // RULE_04
                    d.suspend_flag = 1'b1; // RULE_03
                    d.st = ST_SUSPEND;
                end
            end
            ST_BIT_LOW: begin
                if (timer_done) begin
                    d.st = ST_BIT_HIGH;
                end
            end
            ST_BIT_HIGH: begin
                // A slave holding the clock low stretches the high phase.
                if (!scl_s) begin
                    d.cnt = 8'h00;
                end else if (timer_done) begin
                    lost = cur_bit && !sda_s && ((q.xf != XF_RX && q.idx != 4'h8) ||
                                                  (q.xf == XF_RX && q.idx == 4'h8));
                    d.sh = {q.sh[6:0], 1'b1};
                    if (q.xf == XF_RX && q.idx != 4'h8) begin
                        d.rx = {q.rx[6:0], sda_s};
                    end
                    if (lost) begin
                        d.code = `CODE_LOST; // RULE_12 RULE_14
                        d.owner = 1'b0;
                        d.suspend_flag = 1'b1;
                        d.st = ST_SUSPEND;
                    end else if (q.idx != 4'h8) begin
                        d.idx = q.idx + 4'h1;
                        d.st = ST_BIT_LOW;
                    end else begin
                        d.suspend_flag = 1'b1;
                        d.st = ST_SUSPEND;
                        case (q.xf)
                            XF_ADDR: begin
                                if (q.rx_mode) begin
                                    d.code = ack_rx ? `CODE_AR_ACK : `CODE_AR_NACK; // RULE_14
                                end else begin
                                    d.code = ack_rx ? `CODE_AW_ACK : `CODE_AW_NACK; // RULE_07
                                end
                            end
                            XF_TX: begin
                                d.code = ack_rx ? `CODE_TXD_ACK : `CODE_TXD_NACK; // RULE_07
                            end
                            default: begin
                                d.data_register = q.rx; // RULE_15
                                d.code = q.ack_bit ? `CODE_RXD_ACK : `CODE_RXD_NACK; // RULE_23
                            end
                        endcase
                    end
                end
            end
            ST_SUSPEND: begin
                // While the master still owns the bus the clock stays held low here, so the bus waits for software; after a loss it is released.
                if (!q.suspend_flag) begin // RULE_17
                    d.idx = 4'h0;
                    if (q.code == `CODE_LOST) begin
                        d.st = q.start_request ? ST_WAIT_FREE : ST_IDLE; // RULE_12 RULE_13
                    end else if (q.stop_request) begin
                        d.st = ST_STOP_A; // RULE_10 RULE_11
                    end else if (q.start_request) begin
                        d.st = ST_RS_A; // RULE_09
                    end else if (q.code == `CODE_START || q.code == `CODE_RESTART) begin
                        d.xf = XF_ADDR;
                        d.sh = q.data_register; // RULE_18
                        d.rx_mode = q.data_register[0]; // RULE_05 RULE_06
                        d.st = ST_BIT_LOW;
                    end else if (!q.rx_mode) begin
                        d.xf = XF_TX;
                        d.sh = q.data_register; // RULE_08
                        d.st = ST_BIT_LOW;
                    end else if (q.code == `CODE_AR_ACK || q.code == `CODE_RXD_ACK) begin
                        d.xf = XF_RX;
                        d.ack_bit = q.ack_enable; // RULE_22 RULE_16
                        d.st = ST_BIT_LOW;
                    end else begin
                        // After a NACK in receive mode only STOP or START can follow.
                        d.suspend_flag = 1'b1;
                    end
                end
            end
            ST_RS_A: begin
                if (timer_done) begin
                    d.st = ST_RS_B;
                end
            end
            ST_RS_B: begin
                if (!scl_s) begin
                    d.cnt = 8'h00;
                end else if (timer_done) begin
                    d.st = ST_START_A; // RULE_09
                end
            end
            ST_STOP_A: begin
                if (timer_done) begin
                    d.st = ST_STOP_B;
                end
            end
            ST_STOP_B: begin
                if (!scl_s) begin
                    d.cnt = 8'h00;
                end else if (timer_done) begin
                    d.st = ST_STOP_C;
                end
            end
            ST_STOP_C: begin
                if (timer_done) begin
                    d.owner = 1'b0;
                    d.code = `CODE_IDLE;
                    d.stop_request = 1'b0; // RULE_10 RULE_11
                    d.st = q.start_request ? ST_WAIT_FREE : ST_IDLE; // RULE_11
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        if (!q.interface_enable) begin
            d.st = ST_IDLE; // RULE_19
            d.owner = 1'b0;
        end
        if (d.st != q.st) begin
            d.cnt = 8'h00;
        end

        // Line drive follows the next state so the enables leave a flip-flop.
        next_bit = bit_out(d.xf, d.idx, d.sh, d.ack_bit);
        case (d.st)
            ST_START_A: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b1;
            end
            ST_START_B, ST_STOP_A: begin
                d.scl_oe = 1'b1;
                d.sda_oe = 1'b1;
            end
            ST_BIT_LOW: begin
                // Data moves a cycle after the clock falls, so no receiver sees a false START or STOP.
                d.scl_oe = 1'b1;
                d.sda_oe = (q.st == ST_BIT_LOW) ? ~next_bit : q.sda_oe;
            end
            ST_BIT_HIGH: begin
                d.scl_oe = 1'b0;
                d.sda_oe = ~next_bit;
            end
            ST_SUSPEND: begin
                d.scl_oe = d.owner; // RULE_17
                d.sda_oe = q.sda_oe && d.owner; // RULE_12
            end
            ST_RS_A: begin
                d.scl_oe = 1'b1;
                d.sda_oe = 1'b0;
            end
            ST_STOP_B: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b1;
            end
            default: begin
                d.scl_oe = 1'b0;
                d.sda_oe = 1'b0;
            end
        endcase

        d.irq = d.suspend_flag && d.interrupt_enable; // RULE_24
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.code <= `CODE_IDLE;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Open-drain: only a low is ever driven, the enable carries the level.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign irq = q.irq;
    assign awready = ~q.aw_v;
    assign wready = ~q.w_v;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = ~q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = {24'h000000, q.rdata};
    assign rresp = q.rresp;

endmodule : two_wire_master_sequencer

// ### verif/two_wire_slave_model.sv
// Behavioural target device on the two-wire bus, with pull-up wiring done by the bench.
`timescale 1ns/1ps
module two_wire_slave_model #(
    parameter logic [6:0] ADDR = 7'h50,
    parameter logic [7:0] TX = 8'hC3
) (
    input wire logic scl,
    input wire logic sda,
    output logic pull,
    output logic [7:0] last_rx
);
    logic [7:0] sh = 8'h00;
    int n = 0;
    logic act = 1'h0;
    logic rd = 1'h0;
    logic addr_ph = 1'h0;
    logic mack = 1'h0;
    initial begin
        pull = 1'h0;
        last_rx = 8'h00;
    end
    // A falling data line with the clock high is a START, a rising one a STOP.
    always @(negedge sda) begin
        if (scl) begin
            n = 0;
            addr_ph = 1'h1;
            act = 1'h0;
            pull = 1'h0;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            n = 0;
            act = 1'h0;
            addr_ph = 1'h0;
            pull = 1'h0;
        end
    end
    always @(posedge scl) begin
        if (n == 8) begin
            mack = !sda;
        end else begin
            sh = {sh[6:0], sda};
        end
        n = n + 1;
    end
    // The data line only moves while the clock is low, so no false START or STOP is made.
    always @(negedge scl) begin
        if (n == 8 && addr_ph) begin
            act = (sh[7:1] == ADDR);
            rd = sh[0];
            pull = act;
        end else if (n == 8) begin
            if (act && !rd) begin
                last_rx = sh;
            end
            pull = act && !rd;
        end else if (n == 9) begin
            n = 0;
            pull = act && rd && (addr_ph || mack) && !TX[7];
            addr_ph = 1'h0;
        end else if (n > 0 && act && rd && !addr_ph) begin
            pull = !TX[7-n];
        end
    end
endmodule : two_wire_slave_model

// ### verif/two_wire_master_sequencer_checker.sv
// Concurrent checks on the ports of the two-wire master sequencer.
`timescale 1ns/1ps
module two_wire_master_sequencer_checker #(
    parameter logic [7:0] HALF_CYCLES = 8'h04
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [3:0] araddr,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_pins;
        scl_o == 1'h0 && sda_o == 1'h0;
    endproperty
    a_pins: assert property (p_pins) else $error("open-drain output not low");
    property p_aw_block;
        $rose(bvalid) |-> !$past(awready) && !$past(wready);
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("response before address and data were held");
    property p_ar_block;
        rvalid |-> !arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted during response");
    property p_unmapped;
        arvalid && arready && araddr[3:2] == 2'h3 |=> rvalid && rresp == 2'h2;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_read_ok;
        arvalid && arready && araddr[3:2] != 2'h3 |=> rvalid && rresp == 2'h0 && rdata[31:8] == 24'h0;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("mapped read answer wrong");
    property p_status;
        arvalid && arready && araddr[3:2] == 2'h1 |=> rdata[2:0] == 3'h0 && rdata[7:3] != 5'h0;
    endproperty
    a_status: assert property (p_status) else $error("status low bits not zero");
    property p_pause;
        $rose(irq) |=> ($stable(scl_oe) && $stable(sda_oe)) [*3];
    endproperty
    a_pause: assert property (p_pause) else $error("bus lines moved while suspended");
    property p_irq_fall;
        $fell(irq) |-> bvalid || $past(bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("request dropped without a write");
    property p_start_free;
        $rose(sda_oe) && !scl_oe |-> $past(scl_i, 3) && $past(sda_i, 3);
    endproperty
    a_start_free: assert property (p_start_free) else $error("start driven on a busy bus");
endmodule : two_wire_master_sequencer_checker

bind two_wire_master_sequencer two_wire_master_sequencer_checker #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
    .aclk, .aresetn, .awready, .wready, .bvalid, .arvalid, .arready, .araddr, .rvalid, .rdata, .rresp,
    .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq);

// ### verif/test_two_wire_master_sequencer.sv
// Self-checking bench for the two-wire master sequencer.
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module test_two_wire_master_sequencer;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, jam = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe, irq, pull;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    logic [7:0] last_rx;
    int error_cnt = 0, comparisons = 0;
    // Both lines have pull-ups; any party pulling low wins.
    wire scl = !scl_oe;
    wire sda = !(sda_oe || pull || jam);
    two_wire_master_sequencer #(.HALF_CYCLES(8'h04)) uut (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid,
        .bready(1'h1), .bresp, .arvalid, .arready, .araddr, .rvalid, .rready(1'h1), .rdata, .rresp,
        .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .irq);
    two_wire_slave_model target (.scl(scl), .sda(sda), .pull(pull), .last_rx(last_rx));
    initial begin
        forever #25 aclk = !aclk;
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Response readies stay high, so each answer is taken at the edge it is first seen.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
    endtask : rd
    task automatic wait_bit(input int b, input logic val);
        int n;
        n = 0;
        do begin
            rd(4'h0);
            n++;
        end while (v[b] !== val && n < 400);
        if (n >= 400) error_cnt++;
    endtask : wait_bit
    task automatic step(input logic [7:0] c, input logic [7:0] code);
        wr(4'h0, c);
        wait_bit(7, 1'h1);
        rd(4'h4);
        chk(v, {24'h0, code});
    endtask : step
    task automatic t_regs;
        rd(4'h0);
        chk(v, 32'h0);
        rd(4'h4);
        chk(v, {24'h0, `CODE_IDLE});
        rd(4'hC);
        chk({30'h0, r}, 32'h2);
        wr(4'hC, 8'h55);
        chk({30'h0, r}, 32'h2);
        wr(4'h8, 8'h5A);
        rd(4'h8);
        chk(v, 32'h0);
        rd(4'h0);
        chk({31'h0, v[3]}, 32'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_link;
        step(8'hA5, `CODE_START);
        chk({31'h0, irq}, 32'h1);
        wr(4'h8, 8'hA0);
        step(8'h85, `CODE_AW_ACK);
        wr(4'h8, 8'h3C);
        step(8'h85, `CODE_TXD_ACK);
        chk({24'h0, last_rx}, 32'h3C);
        step(8'hA5, `CODE_RESTART);
        wr(4'h8, 8'hA2);
        step(8'h85, `CODE_AW_NACK);
        step(8'h85, `CODE_TXD_NACK);
        step(8'hA5, `CODE_RESTART);
        wr(4'h8, 8'hA1);
        step(8'h85, `CODE_AR_ACK);
        step(8'hC5, `CODE_RXD_ACK);
        rd(4'h8);
        chk(v, 32'hC3);
        step(8'h85, `CODE_RXD_NACK);
        step(8'hA5, `CODE_RESTART);
        wr(4'h8, 8'hA3);
        step(8'h85, `CODE_AR_NACK);
        wr(4'h0, 8'h95);
        wait_bit(4, 1'h0);
        rd(4'h4);
        chk(v, {24'h0, `CODE_IDLE});
        $display("test link done");
    endtask : t_link
    task automatic t_arb;
        step(8'hA5, `CODE_START);
        wr(4'h8, 8'hA0);
        wr(4'h0, 8'h85);
        // The jam goes on while the clock is still held low, so it reads as a lost bit, not a START.
        jam <= 1'h1;
        wait_bit(7, 1'h1);
        jam <= 1'h0;
        rd(4'h4);
        chk(v, {24'h0, `CODE_LOST});
        chk({30'h0, scl_oe, sda_oe}, 32'h0);
        step(8'hA5, `CODE_START);
        step(8'hB5, `CODE_START);
        rd(4'h0);
        chk({31'h0, v[4]}, 32'h0);
        wr(4'h0, 8'h95);
        wait_bit(4, 1'h0);
        $display("test arbitration done");
    endtask : t_arb
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_link;
        t_arb;
        test_done;
    end
    initial begin
        #2000000;
        error_cnt++;
        test_done;
    end
endmodule : test_two_wire_master_sequencer
